// *** omc_defines.vh ***
// Register map, field positions, reset values and timing counts for the output mixer control block
`ifndef OMC_DEFINES_VH
`define OMC_DEFINES_VH

// Register addresses (7-bit control word address)
`define OMC_ADDR_PWR_ONE      7'h01
`define OMC_ADDR_PWR_THREE    7'h03
`define OMC_ADDR_ADD_CTRL     7'h07
`define OMC_ADDR_BYP_ATTEN    7'h28
`define OMC_ADDR_SPK_MIX      7'h32
`define OMC_ADDR_SPK_GAIN     7'h36
`define OMC_ADDR_MONO_MIX     7'h38

// Power management one fields
`define OMC_TIEOFF_BUF_BIT    2
`define OMC_AMP_BIAS_BIT      3
`define OMC_MIDSHIFT_BIT      8

// Power management three fields
`define OMC_SPK_MIX_EN_BIT    2
`define OMC_MONO_MIX_EN_BIT   3
`define OMC_SPK_POS_EN_BIT    5
`define OMC_SPK_NEG_EN_BIT    6
`define OMC_MONO_OUT_EN_BIT   7

// Additional control fields
`define OMC_SLOW_TICK_BIT     0

// Bypass attenuation fields
`define OMC_SPK_ATTEN_BIT     1
`define OMC_MONO_ATTEN_BIT    2

// Mixer select fields
`define OMC_SPK_DAC_BIT       0
`define OMC_SPK_BYP_BIT       1
`define OMC_SPK_SECOND_MIC_INPUT_BIT      5
`define OMC_MONO_DAC_BIT      0
`define OMC_MONO_BYP_BIT      1
`define OMC_MONO_SECOND_MIC_INPUT_BIT     2

// Speaker gain control fields, plus the mono mute bit of the mono mix register
`define OMC_GAIN_MSB          5
`define OMC_SPK_MUTE_BIT      6
`define OMC_SPK_ZC_BIT        7
`define OMC_MONO_MUTE_BIT     6

// Reset values
`define OMC_RST_PWR_ONE       9'h000
`define OMC_RST_PWR_THREE     9'h000
`define OMC_RST_ADD_CTRL      9'h000
`define OMC_RST_BYP_ATTEN     9'h000
`define OMC_RST_SPK_MIX       9'h001
`define OMC_RST_SPK_GAIN      9'h039
`define OMC_RST_MONO_MIX      9'h000

// Gain code limits: +6dB top, 0dB unity, -57dB bottom
`define OMC_GAIN_MAX          6'h3F
`define OMC_GAIN_UNITY        6'h39
`define OMC_GAIN_MIN          6'h00

// Zero-cross timeout in master clock periods (2 to the 21st)
`define OMC_ZC_TIMEOUT_CYCLES 2097152

`endif

// *** omc_output_mixer_control.v ***
// Output mixer control: registers, speaker and mono mix paths, zero-cross gain update and timeout
// Operation
// - Speaker mix sums DAC, bypass, second_mic_input selected
// - Speaker bypass attenuation 0dB or -10dB
// - Six-bit speaker gain, 1dB steps, reset 0dB
// - Speaker mute drives both outputs to midpoint
// - Negative speaker output is inverse of positive while both legs are enabled
// - Zero-cross bit defers gain change to crossing
// - Pending gain applied after 2^21 clocks timeout
// - Slow tick enable gates the timeout clock
// - Mono mix sums DAC, bypass, second_mic_input selected
// - Mono bypass attenuation 0dB or -10dB
// - Mono mute drives mid-supply reference level
// - Mono output active only while enabled
// - All outputs reset disabled, enabled independently
// - Mixer and speaker stage enables in register three
// - Tie-off, bias and midpoint driver enables
`timescale 1ns/1ps
`include "omc_defines.vh"

module omc_output_mixer_control #(
  parameter DW             = 16,
  parameter TIMEOUT_CYCLES = `OMC_ZC_TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire                 mclk,
  input  wire                 rst_n,
  // Control word write port
  input  wire                 reg_wr_en,
  input  wire [6:0]           reg_addr,
  input  wire [8:0]           reg_wdata,
  // Register readback port
  input  wire [6:0]           reg_rd_addr,
  output reg  [8:0]           reg_rdata,
  // Mixer source samples
  input  wire                 sample_valid,
  input  wire signed [DW-1:0] dac_sample,
  input  wire signed [DW-1:0] bypass_sample,
  input  wire signed [DW-1:0] second_mic_input,
  // Analogue stage enables
  output reg                  tieoff_buffer_enable,
  output reg                  amp_bias_enable,
  output reg                  midpoint_shift_driver_enable,
  output reg                  speaker_mixer_enable,
  output reg                  mono_mixer_enable,
  output reg                  speaker_pos_enable,
  output reg                  speaker_neg_enable,
  output reg                  mono_out_enable,
  // Applied speaker gain and mute levels
  output reg  [5:0]           speaker_gain,
  output reg                  speaker_gain_pending,
  output reg                  output_midpoint_level,
  output reg                  mid_supply_reference,
  // Output samples, zero means midpoint level
  output reg  signed [DW+1:0] speaker_pos_out,
  output reg  signed [DW+1:0] speaker_neg_out,
  output reg  signed [DW+1:0] mono_out_pin
);

  // Two guard bits keep a full-scale sum of three sources from wrapping
  localparam OW = DW + 2;
  localparam CW = 22;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Widen a source to the mix width
  function signed [DW+1:0] widen;
    input signed [DW-1:0] x;
    begin
      widen = {{2{x[DW-1]}}, x};
    end
  endfunction

  // About -10dB: x * 5/16
  function signed [DW+1:0] atten10;
    input signed [DW+1:0] x;
    begin
      atten10 = (x >>> 2) + (x >>> 4);
    end
  endfunction

  // Sum of the selected sources, bypass optionally attenuated
  function signed [DW+1:0] mix3;
    input                 sel_dac;
    input                 sel_byp;
    input                 sel_mic;
    input                 att;
    input signed [DW-1:0] d;
    input signed [DW-1:0] b;
    input signed [DW-1:0] m;
    reg   signed [DW+1:0] bw;
    begin
      bw   = att ? atten10(widen(b)) : widen(b);
      mix3 = (sel_dac ? widen(d) : {OW{1'b0}})
           + (sel_byp ? bw : {OW{1'b0}})
           + (sel_mic ? widen(m) : {OW{1'b0}});
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  reg [8:0] pwr_one_q;
  reg [8:0] pwr_three_q;
  reg [8:0] add_ctrl_q;
  reg [8:0] byp_atten_q;
  reg [8:0] spk_mix_q;
  reg [8:0] spk_gain_ctrl_q;
  reg [8:0] mono_mix_q;

  // Gain writes also steer the update logic further down
  wire wr_spk_gain = reg_wr_en && (reg_addr == `OMC_ADDR_SPK_GAIN);

  // Writes land in the addressed register; unknown addresses are ignored
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_one_q       <= `OMC_RST_PWR_ONE;
      pwr_three_q     <= `OMC_RST_PWR_THREE;
      add_ctrl_q      <= `OMC_RST_ADD_CTRL;
      byp_atten_q     <= `OMC_RST_BYP_ATTEN;
      spk_mix_q       <= `OMC_RST_SPK_MIX;
      spk_gain_ctrl_q <= `OMC_RST_SPK_GAIN;
      mono_mix_q      <= `OMC_RST_MONO_MIX;
    end else if (reg_wr_en) begin
      case (reg_addr)
        `OMC_ADDR_PWR_ONE:   pwr_one_q       <= reg_wdata;
        `OMC_ADDR_PWR_THREE: pwr_three_q     <= reg_wdata;
        `OMC_ADDR_ADD_CTRL:  add_ctrl_q      <= reg_wdata;
        `OMC_ADDR_BYP_ATTEN: byp_atten_q     <= reg_wdata;
        `OMC_ADDR_SPK_MIX:   spk_mix_q       <= reg_wdata;
        `OMC_ADDR_SPK_GAIN:  spk_gain_ctrl_q <= reg_wdata;
        `OMC_ADDR_MONO_MIX:  mono_mix_q      <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Readback mux, registered; unmapped addresses read zero
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 9'h000;
    end else begin
      case (reg_rd_addr)
        `OMC_ADDR_PWR_ONE:   reg_rdata <= pwr_one_q;
        `OMC_ADDR_PWR_THREE: reg_rdata <= pwr_three_q;
        `OMC_ADDR_ADD_CTRL:  reg_rdata <= add_ctrl_q;
        `OMC_ADDR_BYP_ATTEN: reg_rdata <= byp_atten_q;
        `OMC_ADDR_SPK_MIX:   reg_rdata <= spk_mix_q;
        `OMC_ADDR_SPK_GAIN:  reg_rdata <= spk_gain_ctrl_q;
        `OMC_ADDR_MONO_MIX:  reg_rdata <= mono_mix_q;
        default:             reg_rdata <= 9'h000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode

  // Mute and zero-cross bits act on the live register, not on the applied gain
  wire zc_en     = spk_gain_ctrl_q[`OMC_SPK_ZC_BIT];
  wire spk_mute  = spk_gain_ctrl_q[`OMC_SPK_MUTE_BIT];
  wire mono_mute = mono_mix_q[`OMC_MONO_MUTE_BIT];
  wire slow_tick = add_ctrl_q[`OMC_SLOW_TICK_BIT];
  wire [5:0] gain_req = spk_gain_ctrl_q[`OMC_GAIN_MSB:0];

  // Power management one enables, one flop each
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tieoff_buffer_enable         <= 1'b0;
      amp_bias_enable              <= 1'b0;
      midpoint_shift_driver_enable <= 1'b0;
    end else begin
      tieoff_buffer_enable         <= pwr_one_q[`OMC_TIEOFF_BUF_BIT];
      amp_bias_enable              <= pwr_one_q[`OMC_AMP_BIAS_BIT];
      midpoint_shift_driver_enable <= pwr_one_q[`OMC_MIDSHIFT_BIT];
    end
  end

  // Power management three enables; each stage switches on its own
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      speaker_mixer_enable         <= 1'b0;
      mono_mixer_enable            <= 1'b0;
      speaker_pos_enable           <= 1'b0;
      speaker_neg_enable           <= 1'b0;
      mono_out_enable              <= 1'b0;
    end else begin
      speaker_mixer_enable         <= pwr_three_q[`OMC_SPK_MIX_EN_BIT];
      mono_mixer_enable            <= pwr_three_q[`OMC_MONO_MIX_EN_BIT];
      speaker_pos_enable           <= pwr_three_q[`OMC_SPK_POS_EN_BIT];
      speaker_neg_enable           <= pwr_three_q[`OMC_SPK_NEG_EN_BIT];
      mono_out_enable              <= pwr_three_q[`OMC_MONO_OUT_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mix paths

  wire signed [DW+1:0] spk_sum  = mix3(spk_mix_q[`OMC_SPK_DAC_BIT],
                                       spk_mix_q[`OMC_SPK_BYP_BIT],
                                       spk_mix_q[`OMC_SPK_SECOND_MIC_INPUT_BIT],
                                       byp_atten_q[`OMC_SPK_ATTEN_BIT],
                                       dac_sample, bypass_sample, second_mic_input);
  wire signed [DW+1:0] mono_sum = mix3(mono_mix_q[`OMC_MONO_DAC_BIT],
                                       mono_mix_q[`OMC_MONO_BYP_BIT],
                                       mono_mix_q[`OMC_MONO_SECOND_MIC_INPUT_BIT],
                                       byp_atten_q[`OMC_MONO_ATTEN_BIT],
                                       dac_sample, bypass_sample, second_mic_input);

  ////////////////////////////////////////////////////////////////////////////
  // Zero-cross detection on the speaker mix

  reg prev_sign_q;
  reg prev_valid_q;

  // Sign of the speaker mix; a zero sum counts as positive
  wire mix_sign = spk_sum[OW-1];

  // Crossing means a sign change between consecutive valid samples
  wire zero_cross = sample_valid && prev_valid_q && (mix_sign != prev_sign_q);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_sign_q  <= 1'b0;
      prev_valid_q <= 1'b0;
    end else if (sample_valid) begin
      prev_sign_q  <= mix_sign;
      prev_valid_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gain update and timeout

  // Last count before the timeout fires, cut to the counter width on purpose
  localparam [31:0]   TMO_FULL = TIMEOUT_CYCLES - 1;
  localparam [CW-1:0] TMO_LAST = TMO_FULL[CW-1:0];

  reg  [CW-1:0] tmo_cnt_q;
  reg  [CW-1:0] tmo_cnt_d;
  reg  [5:0]    speaker_gain_d;
  reg           gain_pending_d;

  // A direct write, the timeout, and the moment a deferred gain lands
  wire wr_direct = wr_spk_gain && !reg_wdata[`OMC_SPK_ZC_BIT];
  wire tmo_hit   = slow_tick && speaker_gain_pending && (tmo_cnt_q >= TMO_LAST);
  wire apply_now = speaker_gain_pending && (zero_cross || tmo_hit || !zc_en);

  // Next gain: a write with zero-cross off applies at once, otherwise it waits;
  // clearing the zero-cross bit while a change waits releases it at once
  always @* begin
    speaker_gain_d = speaker_gain;
    gain_pending_d = speaker_gain_pending;
    if (wr_direct) begin
      speaker_gain_d = reg_wdata[`OMC_GAIN_MSB:0];
      gain_pending_d = 1'b0;
    end else if (wr_spk_gain) begin
      gain_pending_d = 1'b1;
    end else if (apply_now) begin
      speaker_gain_d = gain_req;
      gain_pending_d = 1'b0;
    end
  end

  // Applied gain and pending flag
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      speaker_gain         <= `OMC_GAIN_UNITY;
      speaker_gain_pending <= 1'b0;
    end else begin
      speaker_gain         <= speaker_gain_d;
      speaker_gain_pending <= gain_pending_d;
    end
  end

  // Next count: cleared by a new write or when idle, frozen at the limit;
  // with the slow tick off a waiting change hangs on a crossing only
  always @* begin
    tmo_cnt_d = tmo_cnt_q;
    if (wr_spk_gain || !speaker_gain_pending) begin
      tmo_cnt_d = {CW{1'b0}};
    end else if (slow_tick && !tmo_hit) begin
      tmo_cnt_d = tmo_cnt_q + 1'b1;
    end
  end

  // Timeout counter
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tmo_cnt_q <= {CW{1'b0}};
    end else begin
      tmo_cnt_q <= tmo_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stages

  // Zero sample code stands for the midpoint level
  localparam [OW-1:0] MID = {OW{1'b0}};

  // Mute level flags follow the mute bits
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      output_midpoint_level <= 1'b0;
      mid_supply_reference  <= 1'b0;
    end else begin
      output_midpoint_level <= spk_mute;
      mid_supply_reference  <= mono_mute;
    end
  end

  // Speaker pair: mute or disable holds the midpoint; negative leg is the inverse
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      speaker_pos_out <= MID;
      speaker_neg_out <= MID;
    end else if (spk_mute || !pwr_three_q[`OMC_SPK_MIX_EN_BIT]) begin
      speaker_pos_out <= MID;
      speaker_neg_out <= MID;
    end else begin
      speaker_pos_out <= pwr_three_q[`OMC_SPK_POS_EN_BIT] ? spk_sum : MID;
      speaker_neg_out <= pwr_three_q[`OMC_SPK_NEG_EN_BIT] ? -spk_sum : MID;
    end
  end

  // Mono output: mute, a stopped mixer or a stopped stage holds the reference
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mono_out_pin <= MID;
    end else if (mono_mute || !pwr_three_q[`OMC_MONO_OUT_EN_BIT] || !pwr_three_q[`OMC_MONO_MIX_EN_BIT]) begin
      mono_out_pin <= MID;
    end else begin
      mono_out_pin <= mono_sum;
    end
  end

endmodule

// *** omc_checker_sva.sv ***
// Port checks for the output mixer control block
`timescale 1ns/1ps
`include "omc_defines.vh"
module omc_checker #(
  parameter DW             = 16,
  parameter TIMEOUT_CYCLES = 16
) (
  // Clock, reset and writes
  input wire                 mclk,
  input wire                 rst_n,
  input wire                 reg_wr_en,
  input wire [6:0]           reg_addr,
  input wire [8:0]           reg_wdata,
  // Stage enables
  input wire                 tieoff_buffer_enable,
  input wire                 amp_bias_enable,
  input wire                 midpoint_shift_driver_enable,
  input wire                 speaker_mixer_enable,
  input wire                 mono_mixer_enable,
  input wire                 speaker_pos_enable,
  input wire                 speaker_neg_enable,
  input wire                 mono_out_enable,
  // Gain, mute levels and samples
  input wire [5:0]           speaker_gain,
  input wire                 speaker_gain_pending,
  input wire                 output_midpoint_level,
  input wire                 mid_supply_reference,
  input wire signed [DW+1:0] speaker_pos_out,
  input wire signed [DW+1:0] speaker_neg_out,
  input wire signed [DW+1:0] mono_out_pin
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Register writes that start the checks
  sequence pw_wr(logic [6:0] a);
    reg_wr_en && reg_addr == a;
  endsequence
  sequence gain_wr(logic zc);
    reg_wr_en && reg_addr == `OMC_ADDR_SPK_GAIN && reg_wdata[`OMC_SPK_ZC_BIT] == zc;
  endsequence
  a_pwr_one_copy: assert property (pw_wr(`OMC_ADDR_PWR_ONE) |-> ##2
    {midpoint_shift_driver_enable, amp_bias_enable, tieoff_buffer_enable} == $past({reg_wdata[8], reg_wdata[3:2]}, 2))
    else $error("power one enables wrong");
  a_pwr_three_copy: assert property (pw_wr(`OMC_ADDR_PWR_THREE) |-> ##2 {mono_out_enable,
    speaker_neg_enable, speaker_pos_enable, mono_mixer_enable, speaker_mixer_enable} == $past({reg_wdata[7:5],
    reg_wdata[3:2]}, 2)) else $error("power three enables wrong");
  a_gain_direct: assert property (gain_wr(1'b0) |-> ##2
    speaker_gain == $past(reg_wdata[5:0], 2) && !speaker_gain_pending) else $error("direct gain wrong");
  a_gain_deferred: assert property (gain_wr(1'b1) |-> ##2 speaker_gain_pending)
    else $error("deferred gain not pending");
  a_gain_hold: assert property (speaker_gain_pending |=> $stable(speaker_gain) || !speaker_gain_pending)
    else $error("gain moved while pending");
  a_bridge_inverse: assert property (speaker_pos_enable && speaker_neg_enable && $past(speaker_pos_enable)
    && $past(speaker_neg_enable) |-> speaker_neg_out == -speaker_pos_out) else $error("negative output not inverse");
  a_spk_mute_mid: assert property (output_midpoint_level && $past(output_midpoint_level) |->
    speaker_pos_out == 0 && speaker_neg_out == 0) else $error("speaker mute not at midpoint");
  a_mono_mute_mid: assert property (mid_supply_reference && $past(mid_supply_reference) |->
    mono_out_pin == 0) else $error("mono mute not at reference");
  a_mono_off_mid: assert property (!mono_out_enable && $past(!mono_out_enable) |-> mono_out_pin == 0)
    else $error("mono output active while off");
endmodule
bind omc_output_mixer_control omc_checker #(.DW(DW), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_omc_checker (.*);

// *** omc_host_model.sv ***
// Host software model driving the control word write port
`timescale 1ns/1ps
module omc_host_model (
  // Clock and write port
  input  wire       mclk,
  output reg        reg_wr_en,
  output reg  [6:0] reg_addr,
  output reg  [8:0] reg_wdata
);
  initial {reg_wr_en, reg_addr, reg_wdata} = 17'h00000;
  // One write launched after an edge, held for the edge that takes it
  task wr(input [6:0] a, input [8:0] d);
    begin
      @(posedge mclk);
      #1;
      {reg_wr_en, reg_addr, reg_wdata} = {1'b1, a, d};
      @(posedge mclk);
      #1;
      {reg_wr_en, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
    end
  endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the output mixer control block
`timescale 1ns/1ps
module tb_top;
  localparam TO = 16;
  // Driven inputs
  reg               mclk = 1'b0, rst_n = 1'b0, sample_valid = 1'b0;
  reg        [6:0]  reg_rd_addr = 7'h00;
  reg signed [15:0] dac_sample = 16'h0000, bypass_sample = 16'h0000, second_mic_input = 16'h0000;
  // Observed outputs
  wire              reg_wr_en, tieoff_buffer_enable, amp_bias_enable, midpoint_shift_driver_enable;
  wire              speaker_mixer_enable, mono_mixer_enable, speaker_pos_enable, speaker_neg_enable;
  wire              mono_out_enable, speaker_gain_pending, output_midpoint_level, mid_supply_reference;
  wire       [6:0]  reg_addr;
  wire       [8:0]  reg_wdata, reg_rdata;
  wire       [5:0]  speaker_gain;
  wire signed [17:0] speaker_pos_out, speaker_neg_out, mono_out_pin;
  // Scoreboard state
  integer           mismatches = 0, n_tests = 0, seed = 32'hd8c0e5d2, cyc = 0, i;
  integer           eb[5] = '{2, 3, 5, 6, 7};
  reg        [6:0]  ad[8] = '{7'h01, 7'h03, 7'h07, 7'h28, 7'h32, 7'h36, 7'h38, 7'h10};
  reg        [8:0]  rv[8] = '{9'h000, 9'h000, 9'h000, 9'h000, 9'h001, 9'h039, 9'h000, 9'h000};
  reg        [17:0] exp_q[$], got, e;
  reg        [2:0]  sel_q[$], s;
  reg signed [17:0] sum;
  reg        [8:0]  d;
  string            nm[8] = '{"rdata", "gain", "pend", "pos", "en", "mute", "neg", "mono"};

  omc_output_mixer_control #(.DW(16), .TIMEOUT_CYCLES(TO)) i_omc_output_mixer_control (.*);
  omc_host_model i_omc_host_model (.*);

  always #20 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task end_sim;
    begin
      if (mismatches == 0 && n_tests > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) begin
      @(posedge mclk);
      #1;
    end
  endtask
  // Note an expected result, flagged at the next edge
  task note(input [2:0] k, input [17:0] x);
    begin
      sel_q.push_back(k);
      exp_q.push_back(x);
      tick(1);
    end
  endtask
  task rd(input [6:0] a, input [8:0] x);
    begin
      reg_rd_addr = a;
      tick(1);
      note(3'd0, {9'h000, x});
    end
  endtask
  // Watcher: compare each flagged result with the oldest note
  always @(posedge mclk) begin
    while (exp_q.size() > 0) begin
      s = sel_q.pop_front();
      e = exp_q.pop_front();
      case (s)
        3'd0: got = {9'h000, reg_rdata};
        3'd1: got = {12'h000, speaker_gain};
        3'd2: got = {17'h00000, speaker_gain_pending};
        3'd3: got = speaker_pos_out;
        3'd4: got = {10'h000, midpoint_shift_driver_enable, amp_bias_enable, tieoff_buffer_enable, mono_out_enable,
                     speaker_neg_enable, speaker_pos_enable, mono_mixer_enable, speaker_mixer_enable};
        3'd5: got = {16'h0000, mid_supply_reference, output_midpoint_level};
        3'd6: got = speaker_neg_out;
        default: got = mono_out_pin;
      endcase
      n_tests = n_tests + 1;
      if (got !== e) begin
        mismatches = mismatches + 1;
        $display("BAD %s exp %h got %h", nm[s], e, got);
      end
    end
  end
  // Cut a hung run short
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      mismatches = mismatches + 1;
      end_sim;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    tick(2);
    rst_n = 1'b1;
    for (i = 0; i < 8; i = i + 1) rd(ad[i], rv[i]);
    for (i = 0; i < 8; i = i + 1) begin
      d = $random(seed);
      i_omc_host_model.wr(ad[i], d);
      rd(ad[i], (i == 7) ? 9'h000 : d);
    end
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    note(3'd1, 18'h39);
    i_omc_host_model.wr(7'h01, 9'h10C);
    tick(1);
    note(3'd4, 18'h0E0);
    for (i = 0; i < 5; i = i + 1) begin
      i_omc_host_model.wr(7'h03, 9'h001 << eb[i]);
      tick(1);
      note(3'd4, 18'h0E0 | (18'h1 << i));
    end
    i_omc_host_model.wr(7'h03, 9'h0EC);
    for (i = 0; i < 8; i = i + 1) begin
      s = i;
      i_omc_host_model.wr(7'h32, {3'b000, s[2], 3'b000, s[1:0]});
      i_omc_host_model.wr(7'h38, {6'h00, s});
      i_omc_host_model.wr(7'h28, {6'h00, s[0], s[0], 1'b0});
      dac_sample = $random(seed);
      bypass_sample = $random(seed) & 16'hFFF0;
      second_mic_input = $random(seed);
      sample_valid = 1'b1;
      tick(2);
      sum = (s[0] ? dac_sample : 16'sh0) + (s[2] ? second_mic_input : 16'sh0)
          + (s[1] ? (s[0] ? (bypass_sample >>> 4) * 5 : bypass_sample) : 16'sh0);
      note(3'd3, sum);
      note(3'd6, -sum);
      note(3'd7, sum);
    end
    i_omc_host_model.wr(7'h03, 9'h06C);
    tick(2);
    note(3'd7, 18'h0);
    i_omc_host_model.wr(7'h03, 9'h0EC);
    i_omc_host_model.wr(7'h36, 9'h079);
    i_omc_host_model.wr(7'h38, 9'h047);
    tick(2);
    note(3'd5, 18'h3);
    note(3'd3, 18'h0);
    note(3'd7, 18'h0);
    i_omc_host_model.wr(7'h36, 9'h000);
    tick(2);
    note(3'd1, 18'h0);
    note(3'd3, sum);
    i_omc_host_model.wr(7'h36, 9'h0BF);
    tick(3 * TO);
    note(3'd2, 18'h1);
    i_omc_host_model.wr(7'h07, 9'h001);
    i_omc_host_model.wr(7'h36, 9'h0BF);
    tick(TO - 4);
    i_omc_host_model.wr(7'h36, 9'h0BF);
    tick(TO - 4);
    note(3'd2, 18'h1);
    for (i = 0; i < 20 && speaker_gain_pending === 1'b1; i = i + 1) tick(1);
    note(3'd1, 18'h3F);
    i_omc_host_model.wr(7'h07, 9'h000);
    i_omc_host_model.wr(7'h36, 9'h0A0);
    tick(2);
    {dac_sample, bypass_sample, second_mic_input} = {-dac_sample, -bypass_sample, -second_mic_input};
    tick(3);
    note(3'd1, 18'h20);
    note(3'd2, 18'h0);
    end_sim;
  end
endmodule
